// [tsi_port_pkg.sv]
// Shared constants for the serial stream port
`default_nettype none

package tsi_port_pkg;

  // ==========================================================================
  // Stream geometry
  localparam int NUM_STREAMS = 16;
  localparam int BYTE_W      = 8;
  localparam int BITCNT_W    = 10;
  localparam int CHAN_W      = 7;
  localparam int STREAM_W    = 4;
  localparam int WORD_W      = STREAM_W + CHAN_W + BYTE_W;
  localparam int FIFO_DEPTH  = 16;

  // ==========================================================================
  // Stream rate field codes
  localparam logic [1:0] RATE_2M = 2'h0;
  localparam logic [1:0] RATE_4M = 2'h1;
  localparam logic [1:0] RATE_8M = 2'h2;

  // Last bit index of a 125 us frame at each rate
  localparam logic [BITCNT_W-1:0] LAST_BIT_2M = 10'h0ff;
  localparam logic [BITCNT_W-1:0] LAST_BIT_4M = 10'h1ff;
  localparam logic [BITCNT_W-1:0] LAST_BIT_8M = 10'h3ff;

  // Channels per stream at each rate
  localparam logic [7:0] CHANS_2M = 8'h20;
  localparam logic [7:0] CHANS_4M = 8'h40;
  localparam logic [7:0] CHANS_8M = 8'h80;

  // ==========================================================================
  // Framing and bit positions
  localparam logic [2:0] BYTE_LAST_BIT  = 3'h7;
  localparam logic [2:0] BYTE_FIRST_BIT = 3'h0;
  localparam logic [3:0] IDLE_RUN       = 4'h8;

endpackage

`default_nettype wire

// [tsi_word_fifo.sv]
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none

module tsi_word_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             i_clk_sys,
  input  wire logic             i_rst,
  // Fill side
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_in_ready,
  // Drain side
  output logic                  o_out_valid,
  output logic [WIDTH-1:0]      o_out_data,
  input  wire logic             i_out_ready
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      count_r;
  logic             push;
  logic             pop;

  assign o_in_ready  = (count_r != (AW+1)'(DEPTH));
  assign o_out_valid = (count_r != '0);
  assign o_out_data  = mem_r[rd_ptr_r];
  assign push        = i_in_valid & o_in_ready;
  assign pop         = o_out_valid & i_out_ready;

  // ==========================================================================
  // Storage
  always_ff @(posedge i_clk_sys) begin
    if (push) begin
      mem_r[wr_ptr_r] <= i_in_data;
    end
  end

  // ==========================================================================
  // Pointers and fill level
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
      end
      if (push && !pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop && !push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// [tsi_serial_stream_port.sv]
// Serial stream framing, receive, transmit and test-data-out logic
// Functional notes
// - Capacity 2048, 1024 or 512 channels total at high, middle, low rate.
// - All sixteen in and out streams run at 2.048, 4.096 or 8.192 Mb/s.
// - Wide select low: frame pulse format identified automatically, either polarity.
// - Wide select high: frames align to an active-low wide frame pulse.
// - Eval pin measures frame offset when select low; is aux clock when high.
// - Each input stream has its own programmable frame offset.
// - Test data out changes on test clock fall; high impedance unless scanning.
// - Reset clears counters; pulse history and idle level load high, channel count 32; serial outputs go high impedance.
`timescale 1ns/1ps
`default_nettype none

module tsi_serial_stream_port (
  // Clock and reset
  input  wire logic                                  i_clk_sys,
  input  wire logic                                  i_rst,
  // Serial link
  input  wire logic                                  i_serial_clk,
  input  wire logic                                  i_frame_sync_in,
  input  wire logic                                  i_frame_eval_or_aux_clock,
  input  wire logic                                  i_wide_frame_select,
  input  wire logic [tsi_port_pkg::NUM_STREAMS-1:0]  i_serial_in_streams,
  output logic      [tsi_port_pkg::NUM_STREAMS-1:0]  o_serial_out_streams,
  output logic      [tsi_port_pkg::NUM_STREAMS-1:0]  o_serial_out_oe_n,
  // Configuration
  input  wire logic [1:0]                            i_stream_rate_field,
  input  wire logic                                  i_offset_wr,
  input  wire logic [tsi_port_pkg::STREAM_W-1:0]     i_offset_stream,
  input  wire logic [tsi_port_pkg::BITCNT_W-1:0]     i_offset_bits,
  // Status
  output logic                                       o_frame_locked,
  output logic                                       o_gci_format,
  output logic      [7:0]                            o_channels_per_stream,
  output logic      [tsi_port_pkg::BITCNT_W-1:0]     o_frame_eval_offset,
  // Transmit byte supply, one byte per stream
  input  wire logic [tsi_port_pkg::NUM_STREAMS*8-1:0] i_tx_bytes,
  output logic                                       o_tx_load,
  // Received word stream
  output logic                                       o_rx_valid,
  output logic      [tsi_port_pkg::WORD_W-1:0]       o_rx_word,
  input  wire logic                                  i_rx_ready,
  // Test access
  input  wire logic                                  i_tck,
  input  wire logic                                  i_tdi,
  input  wire logic                                  i_scan_en,
  output logic                                       o_tdo,
  output logic                                       o_tdo_oe_n
);

  localparam int NS = tsi_port_pkg::NUM_STREAMS;
  localparam int BW = tsi_port_pkg::BITCNT_W;

  typedef enum logic {ALN_HUNT, ALN_LOCKED} align_e;

  function automatic logic [BW-1:0] last_bit_of(input logic [1:0] rate);
    unique case (rate)
      tsi_port_pkg::RATE_4M: last_bit_of = tsi_port_pkg::LAST_BIT_4M;
      tsi_port_pkg::RATE_8M: last_bit_of = tsi_port_pkg::LAST_BIT_8M;
      default:               last_bit_of = tsi_port_pkg::LAST_BIT_2M;
    endcase
  endfunction

  function automatic logic [7:0] chans_of(input logic [1:0] rate);
    unique case (rate)
      tsi_port_pkg::RATE_4M: chans_of = tsi_port_pkg::CHANS_4M;
      tsi_port_pkg::RATE_8M: chans_of = tsi_port_pkg::CHANS_8M;
      default:               chans_of = tsi_port_pkg::CHANS_2M;
    endcase
  endfunction

  // Stream-local bit position, wrapped into the current frame length
  function automatic logic [BW-1:0] local_bit(input logic [BW-1:0] ctr,
                                              input logic [BW-1:0] off,
                                              input logic [BW-1:0] last);
    local_bit = (ctr >= off) ? ctr - off : ctr + (last - off) + 1'b1;
  endfunction

  align_e             state_r;
  logic               sclk_q, fsync_q, aux_q, tck_q;
  logic               half_r;
  logic [BW-1:0]      bit_ctr_r;
  logic [BW-1:0]      last_bit;
  logic               sclk_rise, bit_tick, aux_rise, frame_start;
  logic               std_edge, wide_edge;
  logic [3:0]         run_r;
  logic               idle_lvl_r, idle_known_r, wide_prev_r, meas_arm_r;
  logic [BW-1:0]      offset_r  [NS];
  logic [7:0]         rx_sh_r   [NS];
  logic [7:0]         rx_byte_r [NS];
  logic [tsi_port_pkg::CHAN_W-1:0] rx_chan_r [NS];
  logic [NS-1:0]      pend_r;
  logic [BW-1:0]      lbit      [NS];
  logic [7:0]         tx_sh_r   [NS];
  logic               tdo_cap_r;
  logic               push_valid, push_ready;
  logic [tsi_port_pkg::STREAM_W-1:0] push_idx;
  logic [tsi_port_pkg::WORD_W-1:0]   push_word;

  assign last_bit  = last_bit_of(i_stream_rate_field);
  assign sclk_rise = i_serial_clk & ~sclk_q;
  assign bit_tick  = sclk_rise & half_r;
  assign aux_rise  = i_frame_eval_or_aux_clock & ~aux_q;
  // Pulse leaves its idle level: start of frame in either polarity
  assign std_edge  = sclk_rise & idle_known_r &
                     (fsync_q == idle_lvl_r) &
                     (i_frame_sync_in != idle_lvl_r);
  assign wide_edge = aux_rise & wide_prev_r & ~i_frame_sync_in;
  assign frame_start = i_wide_frame_select ? wide_edge : std_edge;

  // ==========================================================================
  // Input edge history
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      sclk_q  <= 1'b0;
      fsync_q <= 1'b1;
      aux_q   <= 1'b0;
      tck_q   <= 1'b0;
    end else begin
      sclk_q  <= i_serial_clk;
      // Pulse level held from one serial clock rise to the next, so a
      // pulse set up well ahead of the rise is still seen leaving idle
      if (sclk_rise) begin
        fsync_q <= i_frame_sync_in;
      end
      aux_q   <= i_frame_eval_or_aux_clock;
      tck_q   <= i_tck;
    end
  end

  // ==========================================================================
  // Frame format identification
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      run_r        <= '0;
      idle_lvl_r   <= 1'b1;
      idle_known_r <= 1'b0;
      o_gci_format <= 1'b0;
      wide_prev_r  <= 1'b1;
    end else begin
      if (sclk_rise) begin
        // A long steady run marks the idle level of the pulse
        if (i_frame_sync_in != fsync_q) begin
          run_r <= '0;
        end else if (run_r != tsi_port_pkg::IDLE_RUN) begin
          run_r <= run_r + 1'b1;
        end else begin
          idle_lvl_r   <= fsync_q;
          idle_known_r <= 1'b1;
          o_gci_format <= ~fsync_q;
        end
      end
      if (aux_rise) begin
        wide_prev_r <= i_frame_sync_in;
      end
    end
  end

  // ==========================================================================
  // Frame alignment and bit counter
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      state_r   <= ALN_HUNT;
      bit_ctr_r <= '0;
      half_r    <= 1'b0;
    end else begin
      if (frame_start) begin
        state_r   <= ALN_LOCKED;
        bit_ctr_r <= '0;
        half_r    <= 1'b0;
      end else if (sclk_rise) begin
        half_r <= ~half_r;
        if (bit_tick) begin
          bit_ctr_r <= (bit_ctr_r >= last_bit) ? '0 : bit_ctr_r + 1'b1;
        end
      end
    end
  end

  // ==========================================================================
  // Status outputs
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_frame_locked        <= 1'b0;
      o_channels_per_stream <= tsi_port_pkg::CHANS_2M;
    end else begin
      o_frame_locked        <= (state_r == ALN_LOCKED);
      o_channels_per_stream <= chans_of(i_stream_rate_field);
    end
  end

  // ==========================================================================
  // Frame offset measurement on the eval pin
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      meas_arm_r          <= 1'b0;
      o_frame_eval_offset <= '0;
    end else if (!i_wide_frame_select) begin
      if (frame_start) begin
        meas_arm_r <= 1'b1;
      end else if (meas_arm_r && aux_q && !i_frame_eval_or_aux_clock) begin
        o_frame_eval_offset <= bit_ctr_r;
        meas_arm_r          <= 1'b0;
      end
    end else begin
      meas_arm_r <= 1'b0;
    end
  end

  // ==========================================================================
  // Per-stream offsets
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      for (int s = 0; s < NS; s++) begin
        offset_r[s] <= '0;
      end
    end else if (i_offset_wr) begin
      offset_r[i_offset_stream] <= i_offset_bits;
    end
  end

  // ==========================================================================
  // Stream-local bit positions for the current counter value
  always_comb begin
    for (int s = 0; s < NS; s++) begin
      lbit[s] = local_bit(bit_ctr_r, offset_r[s], last_bit);
    end
  end

  // Receive shifters; a byte waits in its slot until the FIFO takes it
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      pend_r <= '0;
      for (int s = 0; s < NS; s++) begin
        rx_sh_r[s]   <= '0;
        rx_byte_r[s] <= '0;
        rx_chan_r[s] <= '0;
      end
    end else begin
      for (int s = 0; s < NS; s++) begin
        if (bit_tick && state_r == ALN_LOCKED) begin
          rx_sh_r[s] <= {rx_sh_r[s][6:0], i_serial_in_streams[s]};
        end
        // New byte wins over the push that clears the slot
        if (bit_tick && state_r == ALN_LOCKED &&
            lbit[s][2:0] == tsi_port_pkg::BYTE_LAST_BIT) begin
          rx_byte_r[s] <= {rx_sh_r[s][6:0], i_serial_in_streams[s]};
          rx_chan_r[s] <= lbit[s][BW-1:3];
          pend_r[s]    <= 1'b1;
        end else if (push_ready && push_valid &&
                     push_idx == tsi_port_pkg::STREAM_W'(s)) begin
          pend_r[s] <= 1'b0;
        end
      end
    end
  end

  // Lowest pending stream goes first; a full FIFO holds every slot
  always_comb begin
    push_idx = '0;
    for (int s = NS - 1; s >= 0; s--) begin
      if (pend_r[s]) begin
        push_idx = tsi_port_pkg::STREAM_W'(s);
      end
    end
  end

  assign push_valid = |pend_r;
  assign push_word  = {push_idx, rx_chan_r[push_idx], rx_byte_r[push_idx]};

  tsi_word_fifo #(
    .WIDTH (tsi_port_pkg::WORD_W),
    .DEPTH (tsi_port_pkg::FIFO_DEPTH)
  ) u_rx_fifo (
    .i_clk_sys   (i_clk_sys),
    .i_rst       (i_rst),
    .i_in_valid  (push_valid),
    .i_in_data   (push_word),
    .o_in_ready  (push_ready),
    .o_out_valid (o_rx_valid),
    .o_out_data  (o_rx_word),
    .i_out_ready (i_rx_ready)
  );

  // ==========================================================================
  // Transmit shifters, MSB first, aligned to channel boundaries
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_serial_out_streams <= '0;
      o_serial_out_oe_n    <= '1;
      o_tx_load            <= 1'b0;
      for (int s = 0; s < NS; s++) begin
        tx_sh_r[s] <= '0;
      end
    end else begin
      o_serial_out_oe_n <= {NS{state_r != ALN_LOCKED}};
      o_tx_load         <= 1'b0;
      if (bit_tick && state_r == ALN_LOCKED) begin
        if (bit_ctr_r[2:0] == tsi_port_pkg::BYTE_FIRST_BIT) begin
          o_tx_load <= 1'b1;
        end
        for (int s = 0; s < NS; s++) begin
          if (bit_ctr_r[2:0] == tsi_port_pkg::BYTE_FIRST_BIT) begin
            o_serial_out_streams[s] <= i_tx_bytes[s*8+7];
            tx_sh_r[s] <= {i_tx_bytes[s*8 +: 7], 1'b0};
          end else begin
            o_serial_out_streams[s] <= tx_sh_r[s][7];
            tx_sh_r[s] <= {tx_sh_r[s][6:0], 1'b0};
          end
        end
      end
    end
  end

  // ==========================================================================
  // Test data out: capture on clock rise, present on clock fall
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      tdo_cap_r  <= 1'b0;
      o_tdo      <= 1'b0;
      o_tdo_oe_n <= 1'b1;
    end else begin
      o_tdo_oe_n <= ~i_scan_en;
      if (i_tck && !tck_q) begin
        tdo_cap_r <= i_tdi;
      end
      if (!i_tck && tck_q) begin
        o_tdo <= tdo_cap_r;
      end
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  AST_CHANS_RATE: assert property (
    ##1 o_channels_per_stream == chans_of($past(i_stream_rate_field)))
    else $error("channel count does not follow rate field");
  AST_BIT_WRAP: assert property (
    bit_tick && !frame_start && bit_ctr_r == last_bit |=> bit_ctr_r == '0)
    else $error("bit counter did not wrap at frame end");
  AST_STD_EDGE: assert property (
    !i_wide_frame_select && frame_start |->
      idle_known_r && i_frame_sync_in != idle_lvl_r &&
      o_gci_format != idle_lvl_r)
    else $error("frame start without a pulse leaving idle level");
  AST_WIDE_EDGE: assert property (
    i_wide_frame_select && frame_start |-> aux_rise && !i_frame_sync_in)
    else $error("wide frame start not on low pulse at aux clock");
  AST_EVAL_HOLD: assert property (
    i_wide_frame_select ##1 i_wide_frame_select |->
      $stable(o_frame_eval_offset))
    else $error("offset measured while eval pin is aux clock");
  AST_OFFSET_WR: assert property (
    i_offset_wr |=> offset_r[$past(i_offset_stream)] == $past(i_offset_bits))
    else $error("stream offset not written");
  AST_TDO_FALL: assert property (
    !(!i_tck && tck_q) |=> $stable(o_tdo))
    else $error("test data out changed away from clock fall");
  AST_HUNT_HIZ: assert property (
    state_r == ALN_HUNT |=> o_serial_out_oe_n == '1)
    else $error("serial outputs driven before alignment");
  AST_FRAME_ZERO: assert property (
    frame_start |=> bit_ctr_r == '0 ##1 o_frame_locked)
    else $error("frame pulse did not restart counters");

endmodule

`default_nettype wire

// [tsi_far_end_model.sv]
// Far-end framer model: shift clock, frame pulse and serial input bytes
`timescale 1ns/1ps
`default_nettype none

module tsi_far_end_model (
  // Control from the bench
  input  wire logic         i_clk_sys,
  input  wire logic         i_run,
  input  wire logic         i_wide,
  input  wire logic         i_idle_lvl,
  input  wire logic [127:0] i_bytes,
  // Link towards the port
  output logic              o_serial_clk,
  output logic              o_frame_sync,
  output logic              o_aux_clk,
  output logic [15:0]       o_serial_in,
  // Byte hand-off
  output logic              o_load,
  output logic [6:0]        o_chan
);
  // Twelve idle rises precede the start, more than the nine needed (ten with a low idle level)
  localparam int START = 12;
  // Eval pin falls once, eight serial clocks after the frame pulse is set
  localparam int EVAL_FALL = START + 8;
  logic [1:0]   p = 2'h0;
  logic [127:0] cur = 128'h0;
  int           cnt = 0;
  int           rel;
  int           b;

  // ==========================================================================
  // Clocks, held still outside a run
  assign o_serial_clk = p[1];
  assign o_aux_clk    = i_wide ? p[1] : !(i_run && cnt >= EVAL_FALL);

  initial begin
    o_frame_sync = 1'b1;
    o_serial_in  = 16'h0;
    o_load       = 1'b0;
    o_chan       = 7'h0;
  end

  // ==========================================================================
  // Pulse and data change two cycles before the rise that samples them
  always @(posedge i_clk_sys) begin
    rel = cnt - START;
    b = rel / 2 - 1;
    o_load <= 1'b0;
    if (!i_run) begin
      p <= 2'h0;
      cnt <= 0;
      o_frame_sync <= i_wide | i_idle_lvl;
      o_serial_in <= ~o_serial_in;
    end else if (p == 2'h3) begin
      p <= 2'h0;
      if (i_wide) begin
        o_frame_sync <= !(rel >= 0 && rel < 4);
      end else begin
        o_frame_sync <= (rel == 0) ? !i_idle_lvl : i_idle_lvl;
      end
      if (rel >= 2 && rel % 2 == 0) begin
        if (b % 8 == 0) begin
          cur = i_bytes;
          o_load <= 1'b1;
          o_chan <= 7'(b / 8);
        end
        for (int s = 0; s < 16; s++) begin
          o_serial_in[s] <= cur[8 * s + 7 - b % 8];
        end
      end else if (rel < 2) begin
        o_serial_in <= ~o_serial_in;
      end
    end else begin
      p <= p + 2'h1;
      cnt <= (p == 2'h1) ? cnt + 1 : cnt;
    end
  end
endmodule
`default_nettype wire

// [tb.sv]
// Self-checking bench for the serial stream port
`timescale 1ns/1ps
`default_nettype none

module tb;
  localparam int WW = tsi_port_pkg::WORD_W;
  logic          clk_sys = 1'b0;
  logic          rst = 1'b1;
  logic [1:0]    rate = 2'h0;
  logic          wide = 1'b0;
  logic          idle_lvl = 1'b1;
  logic          run = 1'b0;
  logic          offset_wr = 1'b0;
  logic [3:0]    offset_stream = 4'h0;
  logic [9:0]    offset_bits = 10'h0;
  logic [127:0]  tx_bytes = 128'h0;
  logic [127:0]  rx_bytes = 128'h0;
  logic          rx_ready = 1'b0;
  logic          tck = 1'b0;
  logic          tdi = 1'b0;
  logic          scan_en = 1'b0;
  logic          collect = 1'b0;
  logic          stall = 1'b1;
  logic          tx_abort = 1'b0;
  logic          sclk;
  logic          fsync;
  logic          aux;
  logic [15:0]   sin;
  logic          m_load;
  logic [6:0]    m_chan;
  logic [15:0]   sout;
  logic [15:0]   oe_n;
  logic          locked;
  logic          gci;
  logic [7:0]    chans;
  logic [9:0]    eval_off;
  logic          tx_load;
  logic          rx_valid;
  logic [WW-1:0] rx_word;
  logic          tdo;
  logic          tdo_oe_n;
  logic [1:0]    offc [16];
  logic [WW-1:0] rxq [$];
  logic [127:0]  txq [$];
  int            mismatches = 0;
  int            total_checks = 0;

  tsi_serial_stream_port tsi_serial_stream_port_inst (
    .i_clk_sys(clk_sys), .i_rst(rst), .i_serial_clk(sclk),
    .i_frame_sync_in(fsync), .i_frame_eval_or_aux_clock(aux),
    .i_wide_frame_select(wide), .i_serial_in_streams(sin),
    .o_serial_out_streams(sout), .o_serial_out_oe_n(oe_n),
    .i_stream_rate_field(rate), .i_offset_wr(offset_wr),
    .i_offset_stream(offset_stream), .i_offset_bits(offset_bits),
    .o_frame_locked(locked), .o_gci_format(gci),
    .o_channels_per_stream(chans), .o_frame_eval_offset(eval_off),
    .i_tx_bytes(tx_bytes), .o_tx_load(tx_load), .o_rx_valid(rx_valid),
    .o_rx_word(rx_word), .i_rx_ready(rx_ready), .i_tck(tck),
    .i_tdi(tdi), .i_scan_en(scan_en), .o_tdo(tdo), .o_tdo_oe_n(tdo_oe_n)
  );

  tsi_far_end_model tsi_far_end_model_inst (
    .i_clk_sys(clk_sys), .i_run(run), .i_wide(wide),
    .i_idle_lvl(idle_lvl), .i_bytes(rx_bytes), .o_serial_clk(sclk),
    .o_frame_sync(fsync), .o_aux_clk(aux), .o_serial_in(sin),
    .o_load(m_load), .o_chan(m_chan)
  );

  always #25 clk_sys = ~clk_sys;

  // ==========================================================================
  // Shared tasks
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic next_tx();
    logic [127:0] v;
    v = {$urandom, $urandom, $urandom, $urandom};
    tx_bytes <= v;
    txq.push_back(v);
  endtask

  task automatic chk_reset();
    @(negedge clk_sys);
    check(oe_n, 16'hffff);
    check(tdo_oe_n, 1'b1);
    check(locked, 1'b0);
    check(rx_valid, 1'b0);
  endtask

  task automatic start_frames(input logic w, input logic idle);
    wide <= w;
    idle_lvl <= idle;
    run <= 1'b1;
    for (int n = 0; n < 400 && locked !== 1'b1; n++) cyc(1);
    @(negedge clk_sys);
    check(locked, 1'b1);
    check(oe_n, 16'h0000);
  endtask

  task automatic stop_run();
    @(posedge clk_sys);
    rst <= 1'b1;
    run <= 1'b0;
    cyc(2);
    chk_reset();
    @(posedge clk_sys);
    rst <= 1'b0;
  endtask

  // ==========================================================================
  // Drivers note each byte they hand over; monitors take the oldest note
  always @(posedge clk_sys) begin
    if (tx_load === 1'b1) next_tx();
    if (m_load === 1'b1) begin
      for (int s = 0; s < 16; s++) begin
        if (collect) rxq.push_back({4'(s),
          7'((m_chan - offc[s]) & 7'h1f), rx_bytes[8 * s +: 8]});
      end
      rx_bytes <= {$urandom, $urandom, $urandom, $urandom};
    end
  end

  always @(posedge clk_sys) begin
    rx_ready <= stall ? 1'b0 : ($urandom % 4 != 0);
    if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
      check(rx_word, (rxq.size() > 0) ? rxq.pop_front() : 'x);
    end
  end

  always @(posedge rst) tx_abort = 1'b1;

  // Each load is followed by eight bit times, MSB first, 8 cycles apart
  always begin
    logic [127:0] txv;
    logic [15:0]  bits;
    @(negedge clk_sys);
    if (tx_load === 1'b1) begin
      txv = txq.pop_front();
      tx_abort = 1'b0;
      for (int k = 0; k < 8; k++) begin
        for (int s = 0; s < 16; s++) bits[s] = txv[8 * s + 7 - k];
        if (!tx_abort) check(sout, bits);
        if (k < 7) repeat (8) @(negedge clk_sys);
      end
    end
  end

  // Generous bound: the sequence needs about 2,600 cycles
  initial begin
    #1000000;
    mismatches++;
    $display("Error at %0t: watchdog expired", $time);
    give_verdict();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    logic [7:0] want [4];
    logic       prev_tdo;
    want = '{tsi_port_pkg::CHANS_2M, tsi_port_pkg::CHANS_4M,
             tsi_port_pkg::CHANS_8M, tsi_port_pkg::CHANS_2M};
    void'($urandom(32'hd4609c9e));
    next_tx();
    cyc(19);
    chk_reset();
    @(posedge clk_sys);
    rst <= 1'b0;
    for (int r = 0; r < 4; r++) begin
      rate <= 2'(r);
      cyc(3);
      @(negedge clk_sys);
      check(chans, want[r]);
      @(posedge clk_sys);
    end
    scan_en <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      tck <= 1'b1;
      tdi <= 1'($urandom);
      cyc(4);
      @(negedge clk_sys);
      if (i > 0) check(tdo, prev_tdo);
      @(posedge clk_sys);
      tck <= 1'b0;
      prev_tdo = tdi;
      cyc(3);
      @(negedge clk_sys);
      check(tdo, prev_tdo);
      check(tdo_oe_n, 1'b0);
      @(posedge clk_sys);
    end
    scan_en <= 1'b0;
    cyc(2);
    @(negedge clk_sys);
    check(tdo_oe_n, 1'b1);
    @(posedge clk_sys);
    // Back-to-back offset writes, whole channels so labels stay exact
    for (int s = 0; s < 16; s++) begin
      offc[s] = 2'($urandom);
      offset_stream <= 4'(s);
      offset_bits <= {5'h0, offc[s], 3'h0};
      offset_wr <= 1'b1;
      cyc(1);
    end
    offset_wr <= 1'b0;
    stall <= 1'b0;
    collect <= 1'b1;
    start_frames(1'b0, 1'b1);
    check(gci, 1'b0);
    cyc(150);
    // A stall longer than a byte time fills the buffer to its depth
    stall <= 1'b1;
    cyc(72);
    stall <= 1'b0;
    // Run past one whole frame so the counters wrap
    cyc(2000);
    collect <= 1'b0;
    for (int n = 0; n < 300 && rxq.size() > 0; n++) cyc(1);
    check(rxq.size(), 0);
    // Eval pin fell eight serial clocks after the pulse: mid bit three
    check(eval_off, 10'h003);
    stop_run();
    stall <= 1'b1;
    start_frames(1'b0, 1'b0);
    check(gci, 1'b1);
    stop_run();
    start_frames(1'b1, 1'b1);
    stop_run();
    give_verdict();
  end
endmodule
`default_nettype wire
